// File: core/ecl_loader.sv
// serial rom configuration loader with strap capture
// assumes all pins are synchronous to core_clk; rom is a microwire x16 part
`timescale 1ns/1ps
module ecl_loader #(
	parameter int WORDS  = 8,
	parameter bit BUS_32 = 1'b0
) (
	input  wire logic                core_clk,
	input  wire logic                reset,
	input  wire logic                hardware_reset_n,
	input  wire logic                serial_rom_enable_strap,
	input  wire logic                serial_rom_data_in,
	input  wire logic [1:0]          internal_bus_speed_ctrl,
	output logic                     serial_rom_clock,
	output logic                     serial_rom_data_out,
	output logic                     serial_rom_select,
	output ecl_pkg::ecl_word_t       cfg_word,
	output logic                     cfg_valid,
	output ecl_pkg::ecl_status_t     status
);

	ecl_pkg::ecl_state_t                state;
	ecl_pkg::ecl_state_t                next_state;
	logic [ecl_pkg::CMD_W-1:0]          cmd_shift;
	logic [ecl_pkg::WORD_W-1:0]         data_shift;
	logic [3:0]                         bit_cnt;
	logic [ecl_pkg::ADDR_W-1:0]         word_cnt;
	logic                               rom_present;
	logic                               bus_16bit;
	logic                               sk_rise;
	logic                               sk_fall;
	logic [ecl_pkg::HALF_W-1:0]         sk_high_len;
	logic                               load_tail;

	// either reset source holds the whole block
	wire hold      = reset || !hardware_reset_n;
	wire releasing = (state == ecl_pkg::ECL_HOLD) && !hold;
	wire in_cmd    = (state == ecl_pkg::ECL_CMD);
	wire in_data   = (state == ecl_pkg::ECL_DATA);
	wire sk_run    = in_cmd || in_data;
	wire cmd_end   = in_cmd && sk_rise && (bit_cnt == ecl_pkg::CMD_LAST);
	wire word_end  = in_data && sk_rise && (bit_cnt == ecl_pkg::WORD_LAST);
	wire last_word = (word_cnt == ecl_pkg::ADDR_W'(WORDS - 1));
	wire [ecl_pkg::WORD_W-1:0] next_data = {data_shift[ecl_pkg::WORD_W-2:0], serial_rom_data_in};

	wire [ecl_pkg::HALF_W-1:0] half_count =
		(internal_bus_speed_ctrl == ecl_pkg::SPD_125MHZ) ? ecl_pkg::HALF_SPD0 :
		(internal_bus_speed_ctrl == ecl_pkg::SPD_83MHZ)  ? ecl_pkg::HALF_SPD1 :
		(internal_bus_speed_ctrl == ecl_pkg::SPD_62MHZ)  ? ecl_pkg::HALF_SPD2 :
		ecl_pkg::HALF_SPD3;

	ecl_sk_gen #(
		.CNT_W      (ecl_pkg::HALF_W)
	) u_sk_gen (
		.core_clk   (core_clk),
		.reset      (hold),
		.run        (sk_run),
		.half_count (half_count),
		.sk         (serial_rom_clock),
		.sk_rise    (sk_rise),
		.sk_fall    (sk_fall)
	);

	always_comb begin
		next_state = state;
		unique case (state)
			ecl_pkg::ECL_HOLD: begin
				if (!hold)
					next_state = serial_rom_enable_strap ? ecl_pkg::ECL_CMD
					                                     : ecl_pkg::ECL_DONE;
			end
			ecl_pkg::ECL_CMD: begin
				if (cmd_end)
					next_state = ecl_pkg::ECL_DATA;
			end
			ecl_pkg::ECL_DATA: begin
				if (load_tail && sk_fall)
					next_state = ecl_pkg::ECL_DONE;
			end
			ecl_pkg::ECL_DONE: begin
				next_state = ecl_pkg::ECL_DONE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (hold)
			state <= ecl_pkg::ECL_HOLD;
		else
			state <= next_state;
	end

	// straps are caught only on the release cycle, never again until reset
	always_ff @(posedge core_clk) begin
		if (hold) begin
			rom_present <= 1'b0;
			bus_16bit   <= 1'b0;
		end else if (releasing) begin
			rom_present <= serial_rom_enable_strap;
			// with a rom fitted the data pin is the rom's output, not a strap
			bus_16bit   <= !serial_rom_enable_strap && serial_rom_data_in && !BUS_32;
		end
	end

	// command bits change on the falling edge so the rom sees them settled
	always_ff @(posedge core_clk) begin
		if (hold)
			cmd_shift <= {ecl_pkg::READ_OP, ecl_pkg::START_ADDR};
		else if (sk_run && sk_fall)
			cmd_shift <= {cmd_shift[ecl_pkg::CMD_W-2:0], 1'b0};
	end

	// last address bit stays until the next fall, so it never moves under a rise
	assign serial_rom_data_out = sk_run && cmd_shift[ecl_pkg::CMD_W-1];
	assign serial_rom_select   = sk_run;

	always_ff @(posedge core_clk) begin
		if (hold || cmd_end || word_end)
			bit_cnt <= 4'h0;
		else if (sk_run && sk_rise)
			bit_cnt <= bit_cnt + 4'h1;
	end

	// last word is in: run on to the next fall so sk never rises outside select
	always_ff @(posedge core_clk) begin
		if (hold)
			load_tail <= 1'b0;
		else if (word_end && last_word)
			load_tail <= 1'b1;
	end

	// sequential read: the rom keeps streaming words after one command
	always_ff @(posedge core_clk) begin
		if (hold) begin
			data_shift <= '0;
			word_cnt   <= '0;
			cfg_word   <= '0;
			cfg_valid  <= 1'b0;
		end else begin
			cfg_valid <= word_end;
			if (in_data && sk_rise)
				data_shift <= next_data;
			if (word_end) begin
				cfg_word <= '{addr: word_cnt, data: next_data};
				word_cnt <= word_cnt + ecl_pkg::ADDR_W'(1);
			end
		end
	end

	assign status = '{rom_present: rom_present,
	                  bus_16bit:   bus_16bit,
	                  load_done:   (state == ecl_pkg::ECL_DONE)};

	// helper: length of the current serial clock high phase
	always_ff @(posedge core_clk) begin
		if (hold || !serial_rom_clock)
			sk_high_len <= '0;
		else
			sk_high_len <= sk_high_len + ecl_pkg::HALF_W'(1);
	end

	property p_load_present;
		@(posedge core_clk) disable iff (reset)
		releasing && serial_rom_enable_strap |=> serial_rom_select ##1 serial_rom_select;
	endproperty
	a_load_present: assert property (p_load_present) else $error("rom present but no load");

	property p_skip_absent;
		@(posedge core_clk) disable iff (reset)
		releasing && !serial_rom_enable_strap |=> status.load_done && !serial_rom_select;
	endproperty
	a_skip_absent: assert property (p_skip_absent) else $error("rom absent but load started");

	property p_start_bit;
		@(posedge core_clk) disable iff (reset)
		$rose(serial_rom_select) |-> serial_rom_data_out && !serial_rom_clock;
	endproperty
	a_start_bit: assert property (p_start_bit) else $error("command does not open with start bit");

	property p_sk_slow;
		@(posedge core_clk) disable iff (hold)
		$fell(serial_rom_clock) && internal_bus_speed_ctrl == ecl_pkg::SPD_25MHZ
			|-> $past(sk_high_len) == ecl_pkg::HALF_SPD3 - 10'h001;
	endproperty
	a_sk_slow: assert property (p_sk_slow) else $error("slow serial clock phase wrong");

	property p_sk_fast;
		@(posedge core_clk) disable iff (hold)
		$fell(serial_rom_clock) && internal_bus_speed_ctrl == ecl_pkg::SPD_125MHZ
			|-> $past(sk_high_len) == ecl_pkg::HALF_SPD0 - 10'h001;
	endproperty
	a_sk_fast: assert property (p_sk_fast) else $error("fast serial clock phase wrong");

	property p_sk_idle;
		@(posedge core_clk) disable iff (hold)
		!serial_rom_select |-> !serial_rom_clock;
	endproperty
	a_sk_idle: assert property (p_sk_idle) else $error("serial clock runs outside a frame");

	property p_sample_in;
		@(posedge core_clk) disable iff (hold)
		word_end |=> cfg_valid && cfg_word.data[0] == $past(serial_rom_data_in);
	endproperty
	a_sample_in: assert property (p_sample_in) else $error("data input not sampled into word");

	property p_width_strap;
		@(posedge core_clk) disable iff (reset)
		releasing && !serial_rom_enable_strap
			|=> bus_16bit == ($past(serial_rom_data_in) && !BUS_32);
	endproperty
	a_width_strap: assert property (p_width_strap) else $error("bus width strap wrong");

	property p_held;
		@(posedge core_clk) disable iff (reset)
		!hardware_reset_n |=> state == ecl_pkg::ECL_HOLD && !serial_rom_select && !rom_present;
	endproperty
	a_held: assert property (p_held) else $error("activity during hardware reset");

	property p_straps_once;
		@(posedge core_clk) disable iff (hold)
		state != ecl_pkg::ECL_HOLD && $past(state) != ecl_pkg::ECL_HOLD
			|-> $stable(rom_present) && $stable(bus_16bit);
	endproperty
	a_straps_once: assert property (p_straps_once) else $error("straps changed after capture");

endmodule : ecl_loader

// File: core/ecl_pkg.sv
// constants, types and timing counts for the serial configuration loader
// assumes a single 250 MHz core clock and a microwire-style serial rom
// Summary of operation
// - enable strap high: rom present, load configuration over the serial link
// - enable strap low or open: rom absent, no serial load at all
// - device drives serial data out with command and address bits during a load
// - speed field 11 (25 MHz bus): serial clock cycle is 4 us
// - speed field 00 (125 MHz bus): serial clock cycle is 800 ns
// - with rom enabled, serial data in is sampled to receive configuration words
// - no rom: data in strap low means 8-bit bus, high 16-bit; 32-bit ignores
// - while hardware reset is low, stay in reset, no load and no strap capture
package ecl_pkg;

	localparam int          CORE_CLK_MHZ = 250;

	// serial clock cycle per speed code; 01 and 10 are interpolated
	localparam int          SK_CYCLE_NS_SPD0 = 800;
	localparam int          SK_CYCLE_NS_SPD1 = 1600;
	localparam int          SK_CYCLE_NS_SPD2 = 2400;
	localparam int          SK_CYCLE_NS_SPD3 = 4000;

	localparam int          HALF_W = 10;
	localparam logic [9:0]  HALF_SPD0 = 10'(SK_CYCLE_NS_SPD0 * CORE_CLK_MHZ / 2000);
	localparam logic [9:0]  HALF_SPD1 = 10'(SK_CYCLE_NS_SPD1 * CORE_CLK_MHZ / 2000);
	localparam logic [9:0]  HALF_SPD2 = 10'(SK_CYCLE_NS_SPD2 * CORE_CLK_MHZ / 2000);
	localparam logic [9:0]  HALF_SPD3 = 10'(SK_CYCLE_NS_SPD3 * CORE_CLK_MHZ / 2000);

	localparam logic [1:0]  SPD_125MHZ = 2'h0;
	localparam logic [1:0]  SPD_83MHZ  = 2'h1;
	localparam logic [1:0]  SPD_62MHZ  = 2'h2;
	localparam logic [1:0]  SPD_25MHZ  = 2'h3;

	// start bit plus read opcode, then a word address
	localparam int          ADDR_W    = 6;
	localparam int          WORD_W    = 16;
	localparam int          CMD_W     = 9;
	localparam logic [2:0]  READ_OP   = 3'h6;
	localparam logic [5:0]  START_ADDR = 6'h00;
	localparam logic [3:0]  CMD_LAST  = 4'h8;
	localparam logic [3:0]  WORD_LAST = 4'hf;

	typedef enum logic [3:0] {
		ECL_HOLD = 4'h1,
		ECL_CMD  = 4'h2,
		ECL_DATA = 4'h4,
		ECL_DONE = 4'h8
	} ecl_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] data;
	} ecl_word_t;

	typedef struct packed {
		logic rom_present;
		logic bus_16bit;
		logic load_done;
	} ecl_status_t;

endpackage : ecl_pkg

// File: core/ecl_sk_gen.sv
// serial clock divider for the configuration rom link
// assumes half_count is at least 1 and stays steady while run is high
`timescale 1ns/1ps
module ecl_sk_gen #(
	parameter int CNT_W = 10
) (
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic             run,
	input  wire logic [CNT_W-1:0] half_count,
	output logic                  sk,
	output logic                  sk_rise,
	output logic                  sk_fall
);

	logic [CNT_W-1:0] count;

	wire at_end = run && (count == half_count - CNT_W'(1));

	// pulses lead the pin change by one cycle so users act on the same edge
	assign sk_rise = at_end && !sk;
	assign sk_fall = at_end && sk;

	always_ff @(posedge core_clk) begin
		if (reset || !run) begin
			count <= '0;
			sk    <= 1'b0;
		end else if (at_end) begin
			count <= '0;
			sk    <= !sk;
		end else begin
			count <= count + CNT_W'(1);
		end
	end

endmodule : ecl_sk_gen

// File: verification/ecl_loader_test.sv
// self-checking bench for the serial configuration loader
// assumes the rom model above; two words loaded to keep the run short
`timescale 1ns/1ps
module ecl_loader_test;
	localparam int        WORDS = 2;
	logic                 core_clk, reset, hardware_reset_n, en_strap, di_strap;
	logic [1:0]           speed;
	logic                 sk, dout, sel, cfg_valid, rom_do;
	ecl_pkg::ecl_word_t   cfg_word;
	ecl_pkg::ecl_status_t status;
	logic [8:0]           cmd_seen;
	logic [31:0]          image;
	logic [15:0]          got [WORDS];
	int                   mismatches, total_checks, seed, nwords, per, cyc, last_rise, nrises;
	wire                  rom_di = en_strap ? rom_do : di_strap;

	ecl_loader #(.WORDS(WORDS)) u_dut (
		.core_clk(core_clk), .reset(reset), .hardware_reset_n(hardware_reset_n),
		.serial_rom_enable_strap(en_strap), .serial_rom_data_in(rom_di),
		.internal_bus_speed_ctrl(speed), .serial_rom_clock(sk),
		.serial_rom_data_out(dout), .serial_rom_select(sel),
		.cfg_word(cfg_word), .cfg_valid(cfg_valid), .status(status));

	ecl_rom_model u_rom (.sk(sk), .sel(sel), .di(dout), .image(image),
		.do_bit(rom_do), .cmd_seen(cmd_seen));

	always #2 core_clk = ~core_clk;
	always @(posedge core_clk) cyc++;
	always @(posedge sk) begin
		per = cyc - last_rise;
		last_rise = cyc;
		nrises++;
	end
	always @(posedge core_clk) if (cfg_valid === 1'b1) begin
		got[cfg_word.addr] <= cfg_word.data;
		nwords <= nwords + 1;
	end

	task automatic check(string what, logic [31:0] exp, logic [31:0] seen);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop

	function automatic int sk_cycles(logic [1:0] spd);
		case (spd)
			2'h0: return 800 / 4;
			2'h1: return ecl_pkg::SK_CYCLE_NS_SPD1 / 4;
			2'h2: return ecl_pkg::SK_CYCLE_NS_SPD2 / 4;
			default: return 4000 / 4;
		endcase
	endfunction : sk_cycles

	// cut: leave the frame running after a few clocks; the next reset cuts it
	task automatic run(logic en, logic di, logic [1:0] spd, logic cut);
		int k, limit;
		@(posedge core_clk);
		#1;
		reset = 1;
		en_strap = en;
		di_strap = di;
		speed = spd;
		nwords = 0;
		nrises = 0;
		image = $random(seed);
		repeat (6) @(posedge core_clk);
		#1 reset = 0;
		hardware_reset_n = 0;
		repeat (4) @(posedge core_clk);
		check("held select", 0, sel);
		check("held status", 0, status);
		#1 hardware_reset_n = 1;
		@(posedge core_clk);
		// strap flipped right after the sampling edge must be ignored
		#1 di_strap = ~di;
		@(posedge core_clk);
		#1;
		check("select at start", en, sel);
		limit = cut ? 5000 : 50000;
		for (k = 0; k < limit && (cut ? nrises < 3 : status.load_done !== 1'b1); k++)
			@(posedge core_clk);
		if (k == limit) begin
			check("load timeout", 0, 1);
			report_and_stop();
		end
		if (cut) begin
			check("sk cycle cut", sk_cycles(spd), per);
			return;
		end
		check("status", {en, ~en & di, 1'b1}, status);
		check("select after", 0, sel);
		if (en) begin
			check("command", 9'h180, cmd_seen);
			check("word count", WORDS, nwords);
			for (k = 0; k < WORDS; k++)
				check("word", image[31 - 16 * k -: 16], got[k]);
			check("sk cycle", sk_cycles(spd), per);
		end else
			check("no words", 0, nwords);
	endtask : run

	initial begin
		core_clk = 0;
		reset = 1;
		hardware_reset_n = 1;
		en_strap = 0;
		di_strap = 0;
		speed = 2'h0;
		image = '0;
		seed = 32'hc5af;
		{mismatches, total_checks, nwords, per, cyc, last_rise, nrises} = '0;
		run(1'b1, 1'b0, 2'h0, 1'b0);
		run(1'b1, 1'b0, 2'h1, 1'b1);
		run(1'b1, 1'b1, 2'h3, 1'b0);
		run(1'b1, 1'b1, 2'h2, 1'b1);
		run(1'b0, 1'b0, 2'h0, 1'b0);
		run(1'b0, 1'b1, 2'h3, 1'b0);
		repeat (4) run(1'($random(seed)), 1'($random(seed)), 2'h0, 1'b0);
		report_and_stop();
	end
endmodule : ecl_loader_test

// File: verification/ecl_rom_model.sv
// behavioural serial configuration rom facing the loader
// assumes select frames one read and sk is idle low between frames
`timescale 1ns/1ps
module ecl_rom_model (
	input  wire logic        sk,
	input  wire logic        sel,
	input  wire logic        di,
	input  wire logic [31:0] image,
	output logic             do_bit,
	output logic [8:0]       cmd_seen
);
	int   nbits;
	logic last;

	initial begin
		nbits = 0;
		last = 1'b0;
		do_bit = 1'b0;
		cmd_seen = '0;
	end

	always @(posedge sel) begin
		nbits = 0;
		cmd_seen = '0;
	end

	always @(posedge sk) if (sel) begin
		if (nbits < 9)
			cmd_seen = {cmd_seen[7:0], di};
		nbits++;
	end

	// new bit on the fall, so it is settled well before the next rise
	always @(negedge sk) if (sel && nbits >= 9 && nbits < 41) begin
		last = image[40 - nbits];
		do_bit = last;
	end

	// a released line falls to the pin's pull-down instead of holding the last bit
	always @(negedge sel) do_bit = 1'b0;
endmodule : ecl_rom_model
